/* File: verilog/tpas_sequencer.sv */
`timescale 1ns/1ps
module tpas_sequencer import tpas_pkg::*; #(
  parameter bit FOUR_INPUT_BUILD = 1'b1
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pacing and configuration from downstream logic.
  input wire logic sample_sync,
  input wire tpas_mode_e mode,
  input wire logic [TPAS_WORD_W-1:0] dither,
  // Shared converter.
  output logic hold,
  output logic [TPAS_CHAN_W-1:0] chan_sel,
  output tpas_sel_e conv_in_sel,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [TPAS_CONV_W-1:0] conv_word,
  input wire logic conv_over,
  input wire logic conv_under,
  output logic [TPAS_WORD_W-1:0] dac_word,
  // Serial output to downstream logic.
  output logic sample_data_serial,
  output logic sample_frame,
  output logic [TPAS_CHAN_W-1:0] sample_chan,
  output logic conv_over_limit_flag,
  output logic conv_under_limit_flag,
  output logic busy
);

  typedef enum logic [2:0] {
    TPAS_ST_IDLE = 3'h0,
    TPAS_ST_START = 3'h1,
    TPAS_ST_WAIT = 3'h2,
    TPAS_ST_PUSH = 3'h3
  } tpas_state_e;

  typedef enum logic [0:0] {
    TPAS_TX_IDLE = 1'h0,
    TPAS_TX_SHIFT = 1'h1
  } tpas_tx_e;

  tpas_state_e state_reg;
  tpas_tx_e tx_reg;
  logic [2:0] sync_pipe_reg;
  logic done_s1_reg, done_s2_reg, done_s3_reg;
  logic [TPAS_CONV_W-1:0] word_s1_reg, word_s2_reg;
  logic over_s1_reg, over_s2_reg, under_s1_reg, under_s2_reg;
  logic [TPAS_CONV_W-1:0] coarse_reg;
  logic [TPAS_WORD_W-1:0] sum_reg;
  logic over_acc_reg, under_acc_reg;
  logic [TPAS_CHAN_W-1:0] last_ch_reg;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  tpas_result_s push_data, pop_data;
  logic [TPAS_WORD_W-1:0] shift_reg;
  logic [TPAS_BITCNT_W-1:0] bit_cnt_reg;
  logic sync_rise, done_rise;

  // Synchronised pacing and converter handshake edges.
  assign sync_rise = sync_pipe_reg[1] && !sync_pipe_reg[2];
  assign done_rise = done_s2_reg && !done_s3_reg;

  // Two-flop synchronisers for signals from outside the domain.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_pipe_reg <= '0;
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
      word_s1_reg <= '0;
      word_s2_reg <= '0;
      over_s1_reg <= 1'b0;
      over_s2_reg <= 1'b0;
      under_s1_reg <= 1'b0;
      under_s2_reg <= 1'b0;
    end else if (ce) begin
      sync_pipe_reg <= {sync_pipe_reg[1:0], sample_sync};
      done_s1_reg <= conv_done;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
      word_s1_reg <= conv_word;
      word_s2_reg <= word_s1_reg;
      over_s1_reg <= conv_over;
      over_s2_reg <= over_s1_reg;
      under_s1_reg <= conv_under;
      under_s2_reg <= under_s1_reg;
    end
  end

  // Conversion sequence: hold, then coarse, residue and clear per channel.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= TPAS_ST_IDLE;
      hold <= 1'b0;
      chan_sel <= '0;
      conv_in_sel <= TPAS_SEL_COARSE;
      conv_start <= 1'b0;
      coarse_reg <= '0;
      dac_word <= '0;
      sum_reg <= '0;
      over_acc_reg <= 1'b0;
      under_acc_reg <= 1'b0;
      last_ch_reg <= '0;
      busy <= 1'b0;
    end else if (ce) begin
      conv_start <= 1'b0;
      unique case (state_reg)
        TPAS_ST_IDLE: begin
          if (sync_rise) begin
            hold <= 1'b1;
            busy <= 1'b1;
            chan_sel <= '0;
            conv_in_sel <= TPAS_SEL_COARSE;
            over_acc_reg <= 1'b0;
            under_acc_reg <= 1'b0;
            if (mode == TPAS_MODE_TWO) begin
              last_ch_reg <= TPAS_LAST_CH_TWO;
            end else if (mode == TPAS_MODE_FOUR && FOUR_INPUT_BUILD) begin
              last_ch_reg <= TPAS_LAST_CH_FOUR;
            end else begin
              last_ch_reg <= '0;
            end
            state_reg <= TPAS_ST_START;
          end
        end
        TPAS_ST_START: begin
          conv_start <= 1'b1;
          state_reg <= TPAS_ST_WAIT;
        end
        TPAS_ST_WAIT: begin
          if (done_rise) begin
            unique case (conv_in_sel)
              TPAS_SEL_COARSE: begin
                coarse_reg <= word_s2_reg;
                dac_word <= {word_s2_reg, {TPAS_CONV_W{1'b0}}} + dither;
                conv_in_sel <= TPAS_SEL_RESIDUE;
                state_reg <= TPAS_ST_START;
              end
              TPAS_SEL_RESIDUE: begin
                sum_reg <= {coarse_reg, {TPAS_CONV_W{1'b0}}} + {{TPAS_CONV_W{1'b0}}, word_s2_reg};
                conv_in_sel <= TPAS_SEL_CLEAR;
                state_reg <= TPAS_ST_START;
              end
              default: begin
                conv_in_sel <= TPAS_SEL_COARSE; // result discarded
                state_reg <= TPAS_ST_PUSH;
              end
            endcase
            over_acc_reg <= over_acc_reg | (over_s2_reg && conv_in_sel != TPAS_SEL_CLEAR);
            under_acc_reg <= under_acc_reg | (under_s2_reg && conv_in_sel != TPAS_SEL_CLEAR);
          end
        end
        TPAS_ST_PUSH: begin
          if (fifo_in_ready) begin
            over_acc_reg <= 1'b0;
            under_acc_reg <= 1'b0;
            if (chan_sel == last_ch_reg) begin
              hold <= 1'b0;
              busy <= 1'b0;
              state_reg <= TPAS_ST_IDLE;
            end else begin
              chan_sel <= chan_sel + 1'b1;
              state_reg <= TPAS_ST_START;
            end
          end
        end
        default: state_reg <= TPAS_ST_IDLE;
      endcase
    end
  end

  // Result handed to the buffer with its channel tag.
  always_comb begin
    push_data.chan = chan_sel;
    push_data.over = over_acc_reg;
    push_data.under = under_acc_reg;
    push_data.data = sum_reg;
  end

  tpas_fifo #(
    .WIDTH(TPAS_RESULT_W),
    .DEPTH(TPAS_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(state_reg == TPAS_ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(pop_data)
  );

  assign fifo_pop = (tx_reg == TPAS_TX_IDLE);

  // Serial shifter, MSB first, frame high during the sixteen bits.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_reg <= TPAS_TX_IDLE;
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      sample_data_serial <= 1'b0;
      sample_frame <= 1'b0;
      sample_chan <= '0;
      conv_over_limit_flag <= 1'b0;
      conv_under_limit_flag <= 1'b0;
    end else if (ce) begin
      unique case (tx_reg)
        TPAS_TX_IDLE: begin
          sample_frame <= 1'b0;
          sample_data_serial <= 1'b0;
          if (fifo_out_valid) begin
            shift_reg <= {pop_data.data[TPAS_WORD_W-2:0], 1'b0};
            sample_data_serial <= pop_data.data[TPAS_WORD_W-1];
            sample_frame <= 1'b1;
            sample_chan <= pop_data.chan;
            conv_over_limit_flag <= pop_data.over;
            conv_under_limit_flag <= pop_data.under;
            bit_cnt_reg <= TPAS_BITS - 1'b1;
            tx_reg <= TPAS_TX_SHIFT;
          end
        end
        TPAS_TX_SHIFT: begin
          if (bit_cnt_reg == '0) begin
            sample_frame <= 1'b0;
            sample_data_serial <= 1'b0;
            tx_reg <= TPAS_TX_IDLE;
          end else begin
            sample_data_serial <= shift_reg[TPAS_WORD_W-1];
            shift_reg <= {shift_reg[TPAS_WORD_W-2:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

endmodule : tpas_sequencer

/* File: verilog/tpas_pkg.sv */
package tpas_pkg;

  // Measurement modes of the channel selector.
  typedef enum logic [1:0] {
    TPAS_MODE_ONE = 2'h0,
    TPAS_MODE_TWO = 2'h1,
    TPAS_MODE_FOUR = 2'h2
  } tpas_mode_e;

  // Converter input selector positions.
  typedef enum logic [1:0] {
    TPAS_SEL_COARSE = 2'h0,
    TPAS_SEL_RESIDUE = 2'h1,
    TPAS_SEL_CLEAR = 2'h2
  } tpas_sel_e;

  localparam int TPAS_CONV_W = 8;
  localparam int TPAS_WORD_W = 16;
  localparam int TPAS_CHAN_W = 2;
  localparam int TPAS_MAX_CH = 4;
  localparam int TPAS_FIFO_DEPTH = 8;
  localparam int TPAS_BITCNT_W = 5;
  localparam logic [1:0] TPAS_LAST_CH_TWO = 2'h1;
  localparam logic [1:0] TPAS_LAST_CH_FOUR = 2'h3;
  localparam logic [TPAS_BITCNT_W-1:0] TPAS_BITS = 5'h10;

  // One finished sample with its overload flags and channel tag.
  typedef struct packed {
    logic [TPAS_CHAN_W-1:0] chan;
    logic over;
    logic under;
    logic [TPAS_WORD_W-1:0] data;
  } tpas_result_s;

  localparam int TPAS_RESULT_W = $bits(tpas_result_s);

endpackage : tpas_pkg

/* File: verilog/tpas_fifo.sv */
`timescale 1ns/1ps
module tpas_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Full and empty follow the occupancy count.
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;

  // Storage writes.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : tpas_fifo

/* File: tb/tpas_chk_assertions.sv */
`timescale 1ns/1ps
module tpas_chk import tpas_pkg::*; (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Watched ports.
  input wire logic sample_sync,
  input wire tpas_mode_e mode,
  input wire logic hold,
  input wire logic [1:0] chan_sel,
  input wire tpas_sel_e conv_in_sel,
  input wire logic conv_start,
  input wire logic busy,
  input wire logic sample_frame,
  input wire logic [1:0] sample_chan
);
  logic [4:0] fcnt_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);
  // Counts the enabled cycles of the current frame.
  always_ff @(posedge clk) begin
    if (!rst_n || !sample_frame) fcnt_reg <= 5'h00;
    else if (ce) fcnt_reg <= fcnt_reg + 5'h01;
  end
  a_sync_hold: assert property (!busy && $rose(sample_sync) |-> ##[2:4] hold) else $error("no hold");
  a_hold_start: assert property ($rose(hold) |=> conv_start) else $error("no start");
  a_start_pulse: assert property (conv_start |-> hold && busy ##1 !conv_start) else $error("bad start");
  a_res_order: assert property (conv_in_sel == TPAS_SEL_RESIDUE && $past(conv_in_sel) != TPAS_SEL_RESIDUE
    |-> $past(conv_in_sel) == TPAS_SEL_COARSE) else $error("bad residue");
  a_clr_order: assert property (conv_in_sel == TPAS_SEL_CLEAR && $past(conv_in_sel) != TPAS_SEL_CLEAR
    |-> $past(conv_in_sel) == TPAS_SEL_RESIDUE) else $error("bad clear");
  a_one_fixed: assert property (busy && mode == TPAS_MODE_ONE |-> chan_sel == 2'h0) else $error("moved");
  a_two_alt: assert property (busy && mode == TPAS_MODE_TWO |-> chan_sel <= 2'h1) else $error("bad two");
  a_chan_step: assert property (busy && $past(busy) && $changed(chan_sel)
    |-> chan_sel == $past(chan_sel) + 2'h1) else $error("bad step");
  a_frame_len: assert property ($fell(sample_frame) |-> fcnt_reg == 5'h10) else $error("bad frame");
  a_tag_hold: assert property (sample_frame && $past(sample_frame) |-> $stable(sample_chan)) else $error("tag");
  c_frame: cover property ($rose(sample_frame));
  c_four: cover property (busy && chan_sel == 2'h3);
  c_clear: cover property (conv_in_sel == TPAS_SEL_CLEAR);
endmodule : tpas_chk

/* File: tb/tpas_conv_model.sv */
`timescale 1ns/1ps
module tpas_conv_model import tpas_pkg::*; (
  // Clock and selector state.
  input wire logic clk,
  input wire logic conv_start,
  input wire logic [1:0] chan_sel,
  input wire tpas_sel_e conv_in_sel,
  // Test pattern.
  input wire logic [7:0] base,
  input wire logic ovr,
  input wire logic und,
  // Converter answer.
  output logic conv_done,
  output logic [7:0] conv_word,
  output logic conv_over,
  output logic conv_under
);
  logic start_q;
  // Answers each rising start after a random delay; data is inverted while the conversion runs.
  initial begin
    start_q = 1'b0;
    conv_done = 1'b0;
    conv_word = 8'h5A;
    conv_over = 1'b0;
    conv_under = 1'b0;
    forever begin
      @(posedge clk);
      #1;
      if (conv_start && !start_q) begin
        conv_done = 1'b0;
        conv_word = ~conv_word;
        conv_over = ~conv_over;
        conv_under = ~conv_under;
        repeat ($urandom_range(2, 6)) @(posedge clk);
        #1;
        conv_word = base ^ {chan_sel, conv_in_sel, 4'h0};
        conv_over = ovr && conv_in_sel == TPAS_SEL_COARSE;
        conv_under = und && conv_in_sel == TPAS_SEL_RESIDUE;
        conv_done = 1'b1;
      end
      start_q = conv_start;
    end
  end
endmodule : tpas_conv_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top import tpas_pkg::*;;
  logic clk, rst_n, sync, cdone, cov, cun, hold, cst, ser, frm, ovf, unf, busy, ovr, und, ce;
  tpas_mode_e mode;
  tpas_sel_e csel;
  logic [15:0] dith, dac;
  logic [7:0] cword, base;
  logic [1:0] chs, schan;
  tpas_result_s q[$];
  tpas_result_s got, e;
  int fail_count, n_compared, k, k2;
  tpas_sequencer tpas_sequencer_i (.clk(clk), .rst_n(rst_n), .ce(ce), .sample_sync(sync), .mode(mode),
    .dither(dith), .hold(hold), .chan_sel(chs), .conv_in_sel(csel), .conv_start(cst), .conv_done(cdone),
    .conv_word(cword), .conv_over(cov), .conv_under(cun), .dac_word(dac), .sample_data_serial(ser),
    .sample_frame(frm), .sample_chan(schan), .conv_over_limit_flag(ovf), .conv_under_limit_flag(unf), .busy(busy));
  tpas_conv_model tpas_conv_model_i (.clk(clk), .conv_start(cst), .chan_sel(chs), .conv_in_sel(csel),
    .base(base), .ovr(ovr), .und(und), .conv_done(cdone), .conv_word(cword), .conv_over(cov), .conv_under(cun));
  // Free running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task stop_test;
    $display("mismatches %0d compares %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task cmp_res(input tpas_result_s g, input tpas_result_s x);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %0t %h %h", $time, g, x);
    end
  endtask : cmp_res
  task cmp_dac(input logic [15:0] g, input logic [15:0] x);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %0t %h %h", $time, g, x);
    end
  endtask : cmp_dac
  function automatic tpas_result_s exp_r(input logic [1:0] ch);
    logic [7:0] c, r;
    c = base ^ {ch, 2'h0, 4'h0};
    r = base ^ {ch, 2'h1, 4'h0};
    exp_r = '{ch, ovr, und, {c, 8'h00} + {8'h00, r}};
  endfunction : exp_r
  // One sample cycle; a second sync edge while busy must be ignored.
  task run(input tpas_mode_e m, input bit extra);
    int n;
    @(negedge clk);
    mode = m;
    base = $urandom;
    ovr = $urandom;
    und = $urandom;
    dith = $urandom;
    n = (m == TPAS_MODE_TWO) ? 2 : (m == TPAS_MODE_FOUR) ? 4 : 1;
    for (int i = 0; i < n; i++) q.push_back(exp_r(2'(i)));
    sync = 1'b1;
    repeat (5) @(negedge clk);
    sync = 1'b0;
    if (extra) begin
      repeat (6) @(negedge clk);
      sync = 1'b1;
      @(negedge clk);
      sync = 1'b0;
      // A short freeze of the clock enable must leave the words in flight intact.
      ce = 1'b0;
      repeat (4) @(negedge clk);
      ce = 1'b1;
    end
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 2000) fail_count++;
    repeat (2) @(negedge clk);
  endtask : run
  // Checks the DAC word and reassembles each serial word, on enabled edges only.
  always @(posedge clk) begin
    if (ce === 1'b1) begin
      if (cst === 1'b1 && csel === TPAS_SEL_RESIDUE) cmp_dac(dac, {base ^ {chs, 6'h00}, 8'h00} + dith);
      if (frm === 1'b1) begin
        if (k2 == 0) got = '{schan, ovf, unf, 16'h0000};
        got.data = {got.data[14:0], ser};
        k2++;
        if (k2 == 16) begin
          if (q.size() == 0) fail_count++;
          else begin
            e = q.pop_front();
            cmp_res(got, e);
          end
          k2 = 0;
        end
      end else k2 = 0;
    end
  end
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    sync = 1'b0;
    ce = 1'b1;
    mode = TPAS_MODE_ONE;
    dith = 16'h0000;
    base = 8'h00;
    ovr = 1'b0;
    und = 1'b0;
    fail_count = 0;
    n_compared = 0;
    k2 = 0;
    void'($urandom(32'h82FA));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 16; i++) run(tpas_mode_e'(i % 4), i == 6);
    k = 0;
    while (q.size() != 0 && k < 500) begin
      @(negedge clk);
      k++;
    end
    if (q.size() != 0) fail_count++;
    stop_test;
  end
  // Cuts a hang short.
  initial begin
    #400000;
    fail_count++;
    stop_test;
  end
endmodule : tb_top
bind tpas_sequencer tpas_chk tpas_chk_i (.clk(clk), .rst_n(rst_n), .sample_sync(sample_sync), .mode(mode),
  .hold(hold), .chan_sel(chan_sel), .conv_in_sel(conv_in_sel), .conv_start(conv_start), .busy(busy),
  .sample_frame(sample_frame), .sample_chan(sample_chan), .ce(ce));
